//--- design/kbchp_pkg.sv
// constants of the keyboard host port
package kbchp_pkg;
    // host i/o addresses
    localparam logic [7:0] ADDR_DATA = 8'h60;
    localparam logic [7:0] ADDR_CMD_STATUS = 8'h64;
    localparam logic [7:0] ADDR_FAST_A20_RESET = 8'h92;
    // mailbox status layout
    localparam int ST_OFULL_BIT = 0;
    localparam int ST_IFULL_BIT = 1;
    localparam int ST_CMD_BIT = 3;
    localparam logic [7:0] ST_USER_MASK = 8'hf4;
    localparam logic [7:0] ST_RESET = 8'h00;
    // fast a20/reset register layout
    localparam logic [7:0] FAST_RESET_VALUE = 8'h24;
    localparam logic [7:0] FAST_FIXED_BITS = 8'h24;
    localparam int FAST_A20_BIT = 1;
    localparam int FAST_RST_BIT = 0;
    // reset/a20 configuration layout
    localparam int CFG_PORT_EN_BIT = 2;
    localparam int CFG_KBD_LATCH_BIT = 3;
    localparam int CFG_AUX_LATCH_BIT = 4;
    // host read of an inaccessible location
    localparam logic [7:0] IDLE_READ = 8'hff;
    // timing
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int SYS_CLK_PERIOD_NS = 20;
    localparam int FAST_RST_DELAY_NS = 14_000;
    localparam int FAST_RST_WIDTH_NS = 6_000;
    localparam int FAST_RST_DELAY_CYC =
        (FAST_RST_DELAY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int FAST_RST_WIDTH_CYC =
        (FAST_RST_WIDTH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    // core clock tick made by a fractional accumulator
    localparam int CORE_CLK_HZ = 12_000_000;
    localparam int CORE_ACC_STEP = CORE_CLK_HZ / 2_000_000;
    localparam int CORE_ACC_MOD = SYS_CLK_HZ / 2_000_000;
    localparam int CORE_ACC_W = 5;
    // pulse timer states
    typedef enum logic [2:0] {
        KBCHP_IDLE = 3'b001,
        KBCHP_DELAY = 3'b010,
        KBCHP_PULSE = 3'b100
    } kbchp_pulse_state_t;
endpackage

//--- design/kbchp_pulse.sv
// delayed low pulse generator for the fast cpu reset
`timescale 1ns/10ps
module kbchp_pulse #(
    parameter int DELAY_CYC = kbchp_pkg::FAST_RST_DELAY_CYC,
    parameter int WIDTH_CYC = kbchp_pkg::FAST_RST_WIDTH_CYC,
    parameter int CNT_W = 12
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // trigger
    input wire logic i_start,
    // active low pulse
    output logic o_pulse_n
);
    localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYC - 1);
    localparam logic [CNT_W-1:0] WIDTH_LAST = CNT_W'(WIDTH_CYC - 1);

    kbchp_pkg::kbchp_pulse_state_t state;
    logic [CNT_W-1:0] count;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state <= kbchp_pkg::KBCHP_IDLE;
            count <= '0;
            o_pulse_n <= 1'b1;
        end else begin
            case (state)
                kbchp_pkg::KBCHP_IDLE: begin
                    count <= '0;
                    o_pulse_n <= 1'b1;
                    if (i_start) begin
                        state <= kbchp_pkg::KBCHP_DELAY;
                    end
                end
                kbchp_pkg::KBCHP_DELAY: begin
                    if (count == DELAY_LAST) begin
                        count <= '0;
                        o_pulse_n <= 1'b0;
                        state <= kbchp_pkg::KBCHP_PULSE;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                kbchp_pkg::KBCHP_PULSE: begin
                    if (count == WIDTH_LAST) begin
                        count <= '0;
                        o_pulse_n <= 1'b1;
                        state <= kbchp_pkg::KBCHP_IDLE;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                default: begin
                    count <= '0;
                    o_pulse_n <= 1'b1;
                    state <= kbchp_pkg::KBCHP_IDLE;
                end
            endcase
        end
    end
endmodule

//--- design/kbchp_host_port.sv
`timescale 1ns/10ps
module kbchp_host_port #(
    parameter int LINE_COUNT = 4
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // host i/o bus
    input wire logic [7:0] i_host_addr,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    output logic o_host_ack,
    // embedded core mailbox access
    input wire logic i_core_data_wr,
    input wire logic [7:0] i_core_data_wdata,
    input wire logic i_core_data_rd,
    output logic [7:0] o_core_data_buffer,
    input wire logic i_core_status_wr,
    input wire logic [7:0] i_core_status_wdata,
    output logic [7:0] o_core_status,
    output logic o_core_input_irq_n,
    output logic o_core_clk_tick,
    // embedded core port bits
    input wire logic i_core_flags_en,
    input wire logic i_core_kbd_irq_port_bit,
    input wire logic i_core_aux_irq_port_bit,
    input wire logic i_core_a20_port_bit,
    input wire logic i_core_cpu_reset_n,
    input wire logic i_kbd_interrupt_raw,
    input wire logic i_aux_interrupt_raw,
    input wire logic [LINE_COUNT-1:0] i_core_line_port,
    output logic [LINE_COUNT-1:0] o_core_line_in,
    // configuration
    input wire logic [7:0] i_reset_a20_config,
    input wire logic i_cpu_reset_polarity,
    // host interrupts and cpu controls
    output logic o_kbd_host_irq,
    output logic o_aux_host_irq,
    output logic o_kbd_interrupt,
    output logic o_aux_interrupt,
    output logic o_fast_a20_signal,
    output logic o_fast_cpu_reset_n,
    output logic o_cpu_a20_mask_n,
    output logic o_cpu_reset_output,
    // open drain serial lines: clk/data for kbd, clk/data for aux
    input wire logic [LINE_COUNT-1:0] i_line_in,
    output logic [LINE_COUNT-1:0] o_line_out,
    output logic [LINE_COUNT-1:0] o_line_oe_n
);
    logic [7:0] out_buffer;
    logic [7:0] in_buffer;
    logic output_buffer_full;
    logic input_buffer_full;
    logic cmd_flag;
    logic [7:0] user_defined_bits;
    logic fast_a20_bit;
    logic fast_rst_bit;
    logic kbd_raw_q;
    logic aux_raw_q;
    logic kbd_latched;
    logic aux_latched;
    logic [kbchp_pkg::CORE_ACC_W-1:0] core_acc;
    logic fast_pulse_n;
    logic [7:0] status_word;
    logic [7:0] fast_word;

    // decoded host accesses
    logic port_en;
    logic host_wr_mbox;
    logic host_rd_data;
    logic host_rd_status;
    logic host_wr_fast;
    logic host_rd_fast;
    logic fast_start;
    logic data_port_read;

    assign port_en = i_reset_a20_config[kbchp_pkg::CFG_PORT_EN_BIT];
    assign host_wr_mbox = i_host_wr &&
        (i_host_addr == kbchp_pkg::ADDR_DATA || i_host_addr == kbchp_pkg::ADDR_CMD_STATUS);
    assign host_rd_data = i_host_rd && i_host_addr == kbchp_pkg::ADDR_DATA;
    assign host_rd_status = i_host_rd && i_host_addr == kbchp_pkg::ADDR_CMD_STATUS;
    assign host_wr_fast = i_host_wr && port_en &&
        i_host_addr == kbchp_pkg::ADDR_FAST_A20_RESET;
    assign host_rd_fast = i_host_rd && port_en &&
        i_host_addr == kbchp_pkg::ADDR_FAST_A20_RESET;
    // a new pulse only on a zero to one change of bit zero
    assign fast_start = host_wr_fast && i_host_wdata[kbchp_pkg::FAST_RST_BIT] &&
        !fast_rst_bit;
    assign data_port_read = host_rd_data;

    always_comb begin
        status_word = user_defined_bits & kbchp_pkg::ST_USER_MASK;
        status_word[kbchp_pkg::ST_OFULL_BIT] = output_buffer_full;
        status_word[kbchp_pkg::ST_IFULL_BIT] = input_buffer_full;
        status_word[kbchp_pkg::ST_CMD_BIT] = cmd_flag;
    end

    always_comb begin
        fast_word = kbchp_pkg::FAST_FIXED_BITS;
        fast_word[kbchp_pkg::FAST_A20_BIT] = fast_a20_bit;
        fast_word[kbchp_pkg::FAST_RST_BIT] = fast_rst_bit;
    end

    // data buffers keep their contents across reset
    always_ff @(posedge i_sys_clk) begin
        if (i_core_data_wr) begin
            out_buffer <= i_core_data_wdata;
        end
        if (host_wr_mbox) begin
            in_buffer <= i_host_wdata;
        end
    end

    // output buffer full: set wins over host read
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            output_buffer_full <= 1'b0;
        end else if (i_core_data_wr) begin
            output_buffer_full <= 1'b1;
        end else if (host_rd_data) begin
            output_buffer_full <= 1'b0;
        end
    end

    // input buffer full: set wins over core read
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            input_buffer_full <= 1'b0;
        end else if (host_wr_mbox) begin
            input_buffer_full <= 1'b1;
        end else if (i_core_data_rd) begin
            input_buffer_full <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cmd_flag <= 1'b0;
        end else if (host_wr_mbox) begin
            cmd_flag <= i_host_addr[2];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            user_defined_bits <= kbchp_pkg::ST_RESET;
        end else if (i_core_status_wr) begin
            user_defined_bits <= i_core_status_wdata & kbchp_pkg::ST_USER_MASK;
        end
    end

    // the data copy is not cleared by reset
    always_ff @(posedge i_sys_clk) begin
        if (i_core_data_rd) begin
            o_core_data_buffer <= in_buffer;
        end
    end

    // core side read-back
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_core_status <= kbchp_pkg::ST_RESET;
            o_core_input_irq_n <= 1'b1;
        end else begin
            o_core_status <= status_word;
            o_core_input_irq_n <= !(input_buffer_full && !i_core_data_rd);
        end
    end

    // fast a20/reset register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            fast_a20_bit <= kbchp_pkg::FAST_RESET_VALUE[kbchp_pkg::FAST_A20_BIT];
            fast_rst_bit <= kbchp_pkg::FAST_RESET_VALUE[kbchp_pkg::FAST_RST_BIT];
        end else if (host_wr_fast) begin
            fast_a20_bit <= i_host_wdata[kbchp_pkg::FAST_A20_BIT];
            fast_rst_bit <= i_host_wdata[kbchp_pkg::FAST_RST_BIT];
        end
    end

    kbchp_pulse #(
        .DELAY_CYC(kbchp_pkg::FAST_RST_DELAY_CYC),
        .WIDTH_CYC(kbchp_pkg::FAST_RST_WIDTH_CYC),
        .CNT_W(12)
    ) u_fast_pulse (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(fast_start),
        .o_pulse_n(fast_pulse_n)
    );

    // host read data, one cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_host_rdata <= kbchp_pkg::IDLE_READ;
            o_host_ack <= 1'b0;
        end else begin
            o_host_ack <= host_rd_data || host_rd_status || host_wr_mbox ||
                host_rd_fast || host_wr_fast;
            if (host_rd_data) begin
                o_host_rdata <= out_buffer;
            end else if (host_rd_status) begin
                o_host_rdata <= status_word;
            end else if (host_rd_fast) begin
                o_host_rdata <= fast_word;
            end else begin
                o_host_rdata <= kbchp_pkg::IDLE_READ;
            end
        end
    end

    // interrupt latches: rising edge sets, data read clears, set wins
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            kbd_raw_q <= 1'b0;
            aux_raw_q <= 1'b0;
            kbd_latched <= 1'b0;
            aux_latched <= 1'b0;
        end else begin
            kbd_raw_q <= i_kbd_interrupt_raw;
            aux_raw_q <= i_aux_interrupt_raw;
            if (i_kbd_interrupt_raw && !kbd_raw_q) begin
                kbd_latched <= 1'b1;
            end else if (data_port_read) begin
                kbd_latched <= 1'b0;
            end
            if (i_aux_interrupt_raw && !aux_raw_q) begin
                aux_latched <= 1'b1;
            end else if (data_port_read) begin
                aux_latched <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_kbd_interrupt <= 1'b0;
            o_aux_interrupt <= 1'b0;
        end else begin
            if (i_reset_a20_config[kbchp_pkg::CFG_KBD_LATCH_BIT]) begin
                o_kbd_interrupt <= kbd_latched;
            end else begin
                o_kbd_interrupt <= i_kbd_interrupt_raw && kbd_latched;
            end
            if (i_reset_a20_config[kbchp_pkg::CFG_AUX_LATCH_BIT]) begin
                o_aux_interrupt <= aux_latched;
            end else begin
                o_aux_interrupt <= i_aux_interrupt_raw && aux_latched;
            end
        end
    end

    // host interrupt lines
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_kbd_host_irq <= 1'b0;
            o_aux_host_irq <= 1'b0;
        end else if (i_core_flags_en) begin
            o_kbd_host_irq <= i_core_kbd_irq_port_bit && output_buffer_full;
            o_aux_host_irq <= i_core_aux_irq_port_bit && !input_buffer_full;
        end else begin
            o_kbd_host_irq <= i_core_kbd_irq_port_bit;
            o_aux_host_irq <= i_core_aux_irq_port_bit;
        end
    end

    // cpu a20 and reset outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_fast_a20_signal <= 1'b0;
            o_fast_cpu_reset_n <= 1'b1;
            o_cpu_a20_mask_n <= 1'b0;
            o_cpu_reset_output <= !i_cpu_reset_polarity;
        end else begin
            o_fast_a20_signal <= fast_a20_bit;
            o_fast_cpu_reset_n <= fast_pulse_n;
            o_cpu_a20_mask_n <= i_core_a20_port_bit || fast_a20_bit;
            o_cpu_reset_output <= (i_core_cpu_reset_n && (fast_pulse_n || !port_en)) ^
                i_cpu_reset_polarity;
        end
    end

    // core clock tick, 6 of every 25 system cycles
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            core_acc <= '0;
            o_core_clk_tick <= 1'b0;
        end else if (core_acc >= kbchp_pkg::CORE_ACC_W'(kbchp_pkg::CORE_ACC_MOD -
                kbchp_pkg::CORE_ACC_STEP)) begin
            core_acc <= core_acc - kbchp_pkg::CORE_ACC_W'(kbchp_pkg::CORE_ACC_MOD -
                kbchp_pkg::CORE_ACC_STEP);
            o_core_clk_tick <= 1'b1;
        end else begin
            core_acc <= core_acc + kbchp_pkg::CORE_ACC_W'(kbchp_pkg::CORE_ACC_STEP);
            o_core_clk_tick <= 1'b0;
        end
    end

    // open drain lines: port bit inverted, a high port bit drives low, a low one releases
    genvar gi;
    generate
        for (gi = 0; gi < LINE_COUNT; gi++) begin : g_line
            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    o_line_out[gi] <= 1'b0;
                    o_line_oe_n[gi] <= 1'b0;
                    o_core_line_in[gi] <= 1'b0;
                end else begin
                    o_line_out[gi] <= 1'b0;
                    o_line_oe_n[gi] <= !i_core_line_port[gi];
                    o_core_line_in[gi] <= i_line_in[gi];
                end
            end
        end
    endgenerate
endmodule

//--- test/kbchp_monitor.sv
// concurrent checks on the keyboard host port
`timescale 1ns/10ps
module kbchp_monitor #(
    parameter int LINE_COUNT = 4
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // host bus and core strobes
    input wire logic [7:0] i_host_addr,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    input wire logic [7:0] i_host_wdata,
    input wire logic i_core_data_wr,
    input wire logic i_core_data_rd,
    input wire logic i_core_flags_en,
    input wire logic i_core_kbd_irq_port_bit,
    input wire logic i_core_a20_port_bit,
    input wire logic i_kbd_interrupt_raw,
    input wire logic [7:0] i_reset_a20_config,
    // watched outputs
    input wire logic [7:0] o_core_status,
    input wire logic o_core_input_irq_n,
    input wire logic o_kbd_host_irq,
    input wire logic o_kbd_interrupt,
    input wire logic o_fast_a20_signal,
    input wire logic o_fast_cpu_reset_n,
    input wire logic o_cpu_a20_mask_n,
    input wire logic [LINE_COUNT-1:0] o_line_oe_n
);
    logic [10:0] since_trig;
    wire logic mb_wr = i_host_wr && (i_host_addr == kbchp_pkg::ADDR_DATA
        || i_host_addr == kbchp_pkg::ADDR_CMD_STATUS);
    wire logic data_rd = i_host_rd && i_host_addr == kbchp_pkg::ADDR_DATA;
    wire logic trig = i_host_wr && i_host_addr == kbchp_pkg::ADDR_FAST_A20_RESET
        && i_reset_a20_config[2] && i_host_wdata[0];
    // cycles since the last trigger
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || trig) begin
            since_trig <= 11'h000;
        end else if (since_trig != 11'h7ff) begin
            since_trig <= since_trig + 11'h001;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    out_full_set_a: assert property (i_core_data_wr |-> ##2 o_core_status[0])
        else $error("out full not set");
    in_full_cmd_a: assert property (mb_wr ##1 !i_core_data_rd |-> ##1 o_core_status[1]
        && o_core_status[3] == $past(i_host_addr[2], 2))
        else $error("in full or cmd flag wrong");
    core_rd_clear_a: assert property (i_core_data_rd && !mb_wr |=> o_core_input_irq_n)
        else $error("core irq not withdrawn");
    out_full_clr_a: assert property (data_rd && !i_core_data_wr ##1 !i_core_data_wr
        |-> ##1 !o_core_status[0])
        else $error("out full not cleared");
    reset_values_a: assert property (disable iff (1'b0) i_sys_rst ##1 i_sys_rst
        |-> o_core_status == 8'h00 && !o_fast_a20_signal && o_fast_cpu_reset_n
        && o_line_oe_n == '0)
        else $error("reset values wrong");
    a20_mask_or_a: assert property (!$past(i_sys_rst)
        |-> o_cpu_a20_mask_n == ($past(i_core_a20_port_bit) | o_fast_a20_signal))
        else $error("a20 mask wrong");
    pulse_width_a: assert property ($fell(o_fast_cpu_reset_n)
        |-> ##299 !o_fast_cpu_reset_n ##1 o_fast_cpu_reset_n)
        else $error("pulse width wrong");
    pulse_delay_a: assert property ($fell(o_fast_cpu_reset_n) |-> since_trig >= 11'h2bc)
        else $error("pulse too early");
    kbd_gate_a: assert property ((i_core_flags_en && !i_core_kbd_irq_port_bit) [*2]
        |-> !o_kbd_host_irq)
        else $error("kbd irq not low");
    kbd_and_mode_a: assert property ((!i_reset_a20_config[3] && !i_kbd_interrupt_raw) [*3]
        |-> !o_kbd_interrupt)
        else $error("kbd int without raw");
    pulse_c: cover property ($fell(o_fast_cpu_reset_n));
    cmd_c: cover property (mb_wr && i_host_addr[2]);
    latch_c: cover property ($rose(o_kbd_interrupt) && i_reset_a20_config[3]);
endmodule
bind kbchp_host_port kbchp_monitor #(.LINE_COUNT(LINE_COUNT)) u_mon (.i_sys_clk, .i_sys_rst,
    .i_host_addr, .i_host_wr, .i_host_rd, .i_host_wdata, .i_core_data_wr, .i_core_data_rd,
    .i_core_flags_en, .i_core_kbd_irq_port_bit, .i_core_a20_port_bit, .i_kbd_interrupt_raw,
    .i_reset_a20_config, .o_core_status, .o_core_input_irq_n, .o_kbd_host_irq,
    .o_kbd_interrupt, .o_fast_a20_signal, .o_fast_cpu_reset_n, .o_cpu_a20_mask_n, .o_line_oe_n);

//--- test/kbchp_host_model.sv
// host processor model issuing i/o reads and writes
`timescale 1ns/10ps
module kbchp_host_model (
    // clock
    input wire logic i_sys_clk,
    // answer from the port
    input wire logic [7:0] i_host_rdata,
    input wire logic i_host_ack,
    // host i/o bus
    output logic [7:0] o_host_addr,
    output logic o_host_wr,
    output logic o_host_rd,
    output logic [7:0] o_host_wdata
);
    initial {o_host_addr, o_host_wr, o_host_rd, o_host_wdata} = 18'h00000;
    // one-cycle strobe, answer a cycle later
    task automatic access(input logic wr, input logic [7:0] addr, wdata,
                          output logic [7:0] rdata, output logic ack);
        @(negedge i_sys_clk);
        o_host_addr <= addr;
        o_host_wdata <= wdata;
        o_host_wr <= wr;
        o_host_rd <= !wr;
        @(negedge i_sys_clk);
        rdata = i_host_rdata;
        ack = i_host_ack;
        o_host_wr <= 1'b0;
        o_host_rd <= 1'b0;
        // released bus carries no stale values
        o_host_addr <= ~addr;
        o_host_wdata <= ~wdata;
    endtask
endmodule

//--- test/tb.sv
// self-checking bench for the keyboard host port
`timescale 1ns/10ps
module tb;
    logic i_sys_clk, i_sys_rst, i_core_data_wr, i_core_data_rd, i_core_status_wr;
    logic [7:0] i_core_data_wdata, i_core_status_wdata, i_reset_a20_config, rd;
    logic i_core_flags_en, i_core_kbd_irq_port_bit, i_core_aux_irq_port_bit, ak;
    logic i_core_a20_port_bit, i_core_cpu_reset_n, i_kbd_interrupt_raw, i_aux_interrupt_raw;
    logic i_cpu_reset_polarity;
    logic [3:0] i_core_line_port;
    wire logic [3:0] i_line_in, o_core_line_in, o_line_out, o_line_oe_n;
    wire logic [7:0] i_host_addr, i_host_wdata, o_host_rdata, o_core_data_buffer, o_core_status;
    wire logic i_host_wr, i_host_rd, o_host_ack, o_core_input_irq_n, o_core_clk_tick;
    wire logic o_kbd_host_irq, o_aux_host_irq, o_kbd_interrupt, o_aux_interrupt;
    wire logic o_fast_a20_signal, o_fast_cpu_reset_n, o_cpu_a20_mask_n, o_cpu_reset_output;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam logic [7:0] FA = kbchp_pkg::ADDR_FAST_A20_RESET;
    localparam logic [7:0] CS = kbchp_pkg::ADDR_CMD_STATUS;
    localparam logic [7:0] DA = kbchp_pkg::ADDR_DATA;
    // pull-ups on released lines
    assign i_line_in = o_line_oe_n | o_line_out;
    kbchp_host_port DUT (.i_sys_clk, .i_sys_rst, .i_host_addr, .i_host_wr, .i_host_rd,
        .i_host_wdata, .o_host_rdata, .o_host_ack, .i_core_data_wr, .i_core_data_wdata,
        .i_core_data_rd, .o_core_data_buffer, .i_core_status_wr, .i_core_status_wdata,
        .o_core_status, .o_core_input_irq_n, .o_core_clk_tick, .i_core_flags_en,
        .i_core_kbd_irq_port_bit, .i_core_aux_irq_port_bit, .i_core_a20_port_bit,
        .i_core_cpu_reset_n, .i_kbd_interrupt_raw, .i_aux_interrupt_raw, .i_core_line_port,
        .o_core_line_in, .i_reset_a20_config, .i_cpu_reset_polarity, .o_kbd_host_irq,
        .o_aux_host_irq, .o_kbd_interrupt, .o_aux_interrupt, .o_fast_a20_signal,
        .o_fast_cpu_reset_n, .o_cpu_a20_mask_n, .o_cpu_reset_output, .i_line_in, .o_line_out,
        .o_line_oe_n);
    kbchp_host_model HOST (.i_sys_clk, .i_host_rdata(o_host_rdata), .i_host_ack(o_host_ack),
        .o_host_addr(i_host_addr), .o_host_wr(i_host_wr), .o_host_rd(i_host_rd),
        .o_host_wdata(i_host_wdata));
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic check(input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    task automatic hw(input logic [7:0] a, input logic [7:0] d);
        HOST.access(1'b1, a, d, rd, ak);
    endtask
    task automatic hr(input logic [7:0] a);
        HOST.access(1'b0, a, 8'h00, rd, ak);
    endtask
    task automatic core(input logic wr, input logic rdp, input logic [7:0] d);
        @(negedge i_sys_clk);
        i_core_data_wr <= wr;
        i_core_data_rd <= rdp;
        i_core_data_wdata <= d;
        @(negedge i_sys_clk);
        i_core_data_wr <= 1'b0;
        i_core_data_rd <= 1'b0;
        idle(1);
    endtask
    task automatic t_mailbox();
        hw(CS, 8'ha5);
        hr(CS);
        check({ak, rd}, 9'h10a);
        check({o_core_input_irq_n, o_aux_host_irq}, 2'b00);
        core(1'b0, 1'b1, 8'h00);
        check(o_core_data_buffer, 8'ha5);
        check({o_core_input_irq_n, o_aux_host_irq}, 2'b11);
        hw(DA, 8'h3c);
        core(1'b0, 1'b1, 8'h00);
        check(o_core_data_buffer, 8'h3c);
        hr(CS);
        check(rd, 8'h00);
        core(1'b1, 1'b0, 8'h5a);
        check(o_kbd_host_irq, 1'b1);
        hr(CS);
        check(rd, 8'h01);
        hr(DA);
        check({ak, rd}, 9'h15a);
        hr(CS);
        check(rd, 8'h00);
        i_core_kbd_irq_port_bit <= 1'b0;
        core(1'b1, 1'b0, 8'h11);
        check(o_kbd_host_irq, 1'b0);
        i_core_flags_en <= 1'b0;
        i_core_kbd_irq_port_bit <= 1'b1;
        idle(2);
        check(o_kbd_host_irq, 1'b1);
        i_core_flags_en <= 1'b1;
        i_core_status_wr <= 1'b1;
        i_core_status_wdata <= 8'hff;
        idle(1);
        i_core_status_wr <= 1'b0;
        hr(DA);
        hr(CS);
        check({ak, rd}, 9'h1f4);
        $display("test mailbox done");
    endtask
    task automatic pulse(input logic want);
        int t = 0;
        int w = 0;
        hw(FA, 8'h01);
        while (o_fast_cpu_reset_n === 1'b1 && t < 1100) begin
            idle(1);
            t++;
        end
        check(t >= 700 && t < 1100, want);
        while (o_fast_cpu_reset_n === 1'b0 && w < 400) begin
            if (w == 5) check(o_cpu_reset_output, 1'b0);
            idle(1);
            w++;
        end
        if (want) check(16'(w), 16'h012c);
    endtask
    task automatic t_fast();
        i_reset_a20_config <= 8'h00;
        hr(FA);
        check({ak, rd}, 9'h0ff);
        hw(FA, 8'h02);
        idle(2);
        check({ak, o_fast_a20_signal}, 2'b00);
        i_reset_a20_config <= 8'h04;
        hw(FA, 8'h02);
        idle(2);
        check({o_fast_a20_signal, o_cpu_a20_mask_n}, 2'b11);
        hr(FA);
        check(rd, 8'h26);
        hw(FA, 8'h00);
        i_core_a20_port_bit <= 1'b1;
        idle(2);
        check({o_fast_a20_signal, o_cpu_a20_mask_n}, 2'b01);
        i_core_a20_port_bit <= 1'b0;
        idle(2);
        check(o_cpu_a20_mask_n, 1'b0);
        pulse(1'b1);
        pulse(1'b0);
        hw(FA, 8'h00);
        pulse(1'b1);
        i_core_cpu_reset_n <= 1'b0;
        idle(3);
        check(o_cpu_reset_output, 1'b0);
        i_cpu_reset_polarity <= 1'b1;
        idle(3);
        check(o_cpu_reset_output, 1'b1);
        i_core_cpu_reset_n <= 1'b1;
        i_cpu_reset_polarity <= 1'b0;
        $display("test fast done");
    endtask
    task automatic t_latch();
        for (int m = 0; m < 2; m++) begin
            i_reset_a20_config <= m ? 8'h04 : 8'h1c;
            i_kbd_interrupt_raw <= 1'b1;
            i_aux_interrupt_raw <= 1'b1;
            idle(4);
            check({o_kbd_interrupt, o_aux_interrupt}, 2'b11);
            i_kbd_interrupt_raw <= 1'b0;
            i_aux_interrupt_raw <= 1'b0;
            idle(4);
            check({o_kbd_interrupt, o_aux_interrupt}, m ? 2'b00 : 2'b11);
            hr(DA);
            idle(3);
            check({o_kbd_interrupt, o_aux_interrupt}, 2'b00);
        end
        $display("test latch done");
    endtask
    task automatic t_misc();
        int n = 0;
        i_core_line_port <= 4'h5;
        repeat (250) begin
            idle(1);
            if (o_core_clk_tick === 1'b1) n++;
        end
        check(16'(n), 16'h003c);
        check({o_line_oe_n, o_core_line_in}, 8'haa);
        hw(FA, 8'h02);
        i_sys_rst <= 1'b1;
        idle(76);
        check({o_core_status, o_line_oe_n, o_line_out}, 16'h0000);
        check({o_fast_a20_signal, o_fast_cpu_reset_n}, 2'b01);
        check(o_core_data_buffer, 8'h3c);
        i_sys_rst <= 1'b0;
        $display("test misc done");
    endtask
    initial begin
        i_sys_rst = 1'b1;
        {i_core_data_wr, i_core_data_rd, i_core_status_wr, i_core_a20_port_bit} = 4'h0;
        {i_core_data_wdata, i_core_status_wdata, i_core_line_port} = 20'h00000;
        {i_kbd_interrupt_raw, i_aux_interrupt_raw, i_cpu_reset_polarity} = 3'b000;
        {i_core_flags_en, i_core_kbd_irq_port_bit, i_core_aux_irq_port_bit} = 3'b111;
        i_core_cpu_reset_n = 1'b1;
        i_reset_a20_config = 8'h04;
        idle(76);
        check({o_core_status, o_line_oe_n, o_line_out}, 16'h0000);
        i_sys_rst <= 1'b0;
        hr(FA);
        check({ak, rd}, 9'h124);
        hr(CS);
        check({ak, rd}, 9'h100);
        t_mailbox();
        t_fast();
        t_latch();
        t_misc();
        complete_run();
    end
endmodule
